// ---- serial_config_command_core.sv ----
// Serial command decoder, configuration registers and channel select.
// Assumes the controller clocks commands on serial_cmd_clock and
// keeps that clock running through trailing zeros and reset.
`timescale 1ns/1ps
`default_nettype none
`include "serial_cmd_core_defines.svh"

// Notes on behaviour
// - Frame is 28 bits MSB first: start, read flag, address, select, data, odd parity.
// - Command data is sampled on each rising command clock edge.
// - One 16-bit configuration word and five 6-bit threshold registers, all readable.
// - Select 6 reads back the fixed logic revision.
// - Select 7 reads accepted write count, zero at reset, wraps after 63.
// - Select 8 reads rejected command count, wraps after 63.
// - Select 9 reads completed command loop count, wraps after 63.
// - Select 10 reads the strapped chip address.
// - Valid reads only get a 17-bit reply: start one, then 16 data bits.
// - Narrow registers reply with zeros in unused upper bits.
// - Writes execute for own strapped address or broadcast 1F.
// - Reads execute only for own address; broadcast replies only when the strapped address is 1F.
// - Select 0 writes config word; selects 1 to 5 write thresholds.
// - Read-only selects 6 to 10: revision, writes, rejects, loops, address.
// - Channel select flip-flop clocks on rising hold edge.
// - Auto mode follows overflow comparator; manual follows config bit 3.
// - Channel indicator high when high energy channel is selected.
// - Channel selection never appears in serial replies.
// - Hold input switches sample-and-hold from tracking to holding.
// - Each strobe assertion fires one test charge pulse while config bit 1 is set.
// - Five strap inputs define the chip address for matching.
module serial_config_command_core
(
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         serial_cmd_clock,
  input  wire logic                         serial_cmd_in,
  input  wire logic [4:0]                   id_strap_pins,
  input  wire logic                         hold_in,
  input  wire logic                         strobe_in,
  input  wire logic                         range_overflow_comparator,
  output logic                              return_data,
  output var serial_cmd_pkg::config_out_type config_out,
  output logic                              sample_hold,
  output logic                              test_pulse,
  output logic                              channel_indicator
);

  // ****************************************
  // Link domain: reset and strap synchronisers
  // ****************************************
  logic                           lrst_meta_reg;
  logic                           lrst_reg;
  logic [4:0]                     strap_meta_reg;
  logic [4:0]                     strap_reg;
  serial_cmd_pkg::link_state_type ls_reg;
  serial_cmd_pkg::link_state_type ls_next;

  always_ff @(posedge serial_cmd_clock)
  begin
    lrst_meta_reg  <= rst;
    lrst_reg       <= lrst_meta_reg;
    strap_meta_reg <= id_strap_pins;
    strap_reg      <= strap_meta_reg;
  end

  // ****************************************
  // Frame decode
  // ****************************************
  logic [27:0] frame;
  logic [4:0]  f_addr;
  logic [3:0]  f_sel;
  logic [15:0] f_data;
  logic        f_read;
  logic        frame_done;
  logic        frame_ok;
  logic        wr_ok;
  logic        rd_ok;
  logic [15:0] rd_data;
  logic [2:0]  thr_idx;

  assign frame      = {ls_reg.shreg, serial_cmd_in};
  assign f_addr     = frame[`ADDR_MSB:`ADDR_LSB];
  assign f_sel      = frame[`SEL_MSB:`SEL_LSB];
  assign f_data     = frame[`DATA_MSB:`DATA_LSB];
  assign f_read     = frame[`RW_POS];
  assign thr_idx    = 3'(f_sel - 4'h1);
  assign frame_done = (ls_reg.phase == serial_cmd_pkg::LINK_SHIFT) && (ls_reg.cnt == `FRAME_LAST);
  assign frame_ok   = frame[`START_POS] && (^frame[26:0]);
  assign wr_ok      = frame_ok && !f_read && (f_sel <= `SEL_THR5)
                      && (f_addr == strap_reg || f_addr == `BROADCAST_ADDR);
  assign rd_ok      = frame_ok && f_read && (f_sel <= `SEL_STRAP_ID)
                      && (f_addr == strap_reg);

  // Channel select state is deliberately absent from this mux
  always_comb
  begin
    case (f_sel)
      `SEL_CONFIG:     rd_data = ls_reg.cfg;
      `SEL_REVISION:   rd_data = `LOGIC_REVISION;
      `SEL_WRITE_CNT:  rd_data = {10'h000, ls_reg.wr_cnt};
      `SEL_REJECT_CNT: rd_data = {10'h000, ls_reg.rej_cnt};
      `SEL_LOOP_CNT:   rd_data = {10'h000, ls_reg.loop_cnt};
      `SEL_STRAP_ID:   rd_data = {11'h000, strap_reg};
      default:
      begin
        if (f_sel <= `SEL_THR5)
          rd_data = {10'h000, ls_reg.thr[thr_idx]};
        else
          rd_data = 16'h0000;
      end
    endcase
  end

  // ****************************************
  // Command state machine
  // ****************************************
  always_comb
  begin
    ls_next = ls_reg;
    case (ls_reg.phase)
      serial_cmd_pkg::LINK_IDLE:
      begin
        ls_next.ret = 1'b0;
        if (serial_cmd_in)
        begin
          ls_next.shreg = {26'h0, 1'b1};
          ls_next.cnt   = 5'd1;
          ls_next.phase = serial_cmd_pkg::LINK_SHIFT;
        end
      end
      serial_cmd_pkg::LINK_SHIFT:
      begin
        ls_next.shreg = {ls_reg.shreg[25:0], serial_cmd_in};
        ls_next.cnt   = ls_reg.cnt + 5'd1;
        if (frame_done)
        begin
          if (rd_ok)
          begin
            // Reply fits inside the trailing zeros
            ls_next.phase = serial_cmd_pkg::LINK_REPLY;
            ls_next.ret   = 1'b1;
            ls_next.shreg = {11'h000, rd_data};
            ls_next.cnt   = 5'd0;
          end
          else
          begin
            ls_next.phase    = serial_cmd_pkg::LINK_IDLE;
            ls_next.loop_cnt = ls_reg.loop_cnt + 6'h01;
            if (wr_ok)
            begin
              if (f_sel == `SEL_CONFIG)
                ls_next.cfg = f_data;
              else
                ls_next.thr[thr_idx] = f_data[5:0];
              ls_next.wr_cnt = ls_reg.wr_cnt + 6'h01;
              ls_next.wr_tgl = ~ls_reg.wr_tgl;
            end
            else
              ls_next.rej_cnt = ls_reg.rej_cnt + 6'h01;
          end
        end
      end
      serial_cmd_pkg::LINK_REPLY:
      begin
        ls_next.ret   = ls_reg.shreg[15];
        ls_next.shreg = {ls_reg.shreg[25:0], 1'b0};
        ls_next.cnt   = ls_reg.cnt + 5'd1;
        if (ls_reg.cnt == `REPLY_DATA_LAST)
        begin
          ls_next.phase    = serial_cmd_pkg::LINK_IDLE;
          ls_next.loop_cnt = ls_reg.loop_cnt + 6'h01;
        end
      end
      default:
      begin
        ls_next.phase = serial_cmd_pkg::LINK_IDLE;
      end
    endcase
    if (lrst_reg)
    begin
      ls_next.phase    = serial_cmd_pkg::LINK_IDLE;
      ls_next.shreg    = 27'h0;
      ls_next.cnt      = 5'd0;
      ls_next.cfg      = `CONFIG_RESET;
      ls_next.thr      = {5{`THR_RESET}};
      ls_next.wr_cnt   = `COUNT_RESET;
      ls_next.rej_cnt  = `COUNT_RESET;
      ls_next.loop_cnt = `COUNT_RESET;
      ls_next.ret      = 1'b0;
      ls_next.wr_tgl   = 1'b0;
    end
  end

  always_ff @(posedge serial_cmd_clock)
  begin
    ls_reg <= ls_next;
  end

  assign return_data = ls_reg.ret;

  // ****************************************
  // Link domain checks
  // ****************************************
  a_reply_start: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && rd_ok |=> ls_reg.ret && ls_reg.phase == serial_cmd_pkg::LINK_REPLY)
    else $error("reply start bit missing");

  a_reply_length: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    ls_reg.phase == serial_cmd_pkg::LINK_REPLY && ls_reg.cnt == 5'd0
    |-> ##16 (ls_reg.phase == serial_cmd_pkg::LINK_IDLE) ##1 !ls_reg.ret)
    else $error("reply length wrong");

  a_bcast_silent: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && f_read && f_addr == `BROADCAST_ADDR && strap_reg != `BROADCAST_ADDR
    |=> ls_reg.phase == serial_cmd_pkg::LINK_IDLE && !ls_reg.ret)
    else $error("broadcast read replied");

  a_config_write: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && wr_ok && f_sel == `SEL_CONFIG |=> ls_reg.cfg == $past(f_data))
    else $error("config word not written");

  a_reject_count: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && !wr_ok && !rd_ok
    |=> ls_reg.rej_cnt == 6'($past(ls_reg.rej_cnt) + 6'h01) && $stable(ls_reg.cfg) && !ls_reg.ret)
    else $error("reject not counted or state changed");

  a_write_count: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && wr_ok |=> ls_reg.wr_cnt == 6'($past(ls_reg.wr_cnt) + 6'h01))
    else $error("write count not advanced");

  a_ro_write: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && !f_read && f_sel > `SEL_THR5 |=> $stable(ls_reg.thr) && $stable(ls_reg.cfg))
    else $error("read-only select altered registers");

  a_zero_fill: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && rd_ok && f_sel != `SEL_CONFIG && f_sel != `SEL_REVISION
    |=> ls_reg.shreg[15:6] == 10'h000)
    else $error("reply upper bits not zero");

  a_reset_state: assert property (@(posedge serial_cmd_clock)
    lrst_reg
    |=> ls_reg.phase == serial_cmd_pkg::LINK_IDLE && ls_reg.wr_cnt == `COUNT_RESET
        && ls_reg.cfg == `CONFIG_RESET && !ls_reg.ret)
    else $error("link state not reset");

  a_loop_frame: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && !rd_ok
    |=> ls_reg.loop_cnt == 6'($past(ls_reg.loop_cnt) + 6'h01))
    else $error("loop count not advanced after frame");

  a_loop_reply: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    ls_reg.phase == serial_cmd_pkg::LINK_REPLY && ls_reg.cnt == `REPLY_DATA_LAST
    |=> ls_reg.loop_cnt == 6'($past(ls_reg.loop_cnt) + 6'h01))
    else $error("loop count not advanced after reply");

  a_thr_write: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && wr_ok && f_sel != `SEL_CONFIG
    |=> ls_reg.thr[$past(thr_idx)] == $past(f_data[5:0]))
    else $error("threshold not written");

  a_read_keeps: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && f_read
    |=> $stable(ls_reg.cfg) && $stable(ls_reg.thr) && $stable(ls_reg.wr_cnt))
    else $error("read altered registers");

  a_reply_bits: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && rd_ok
    |-> ##2 (ls_reg.ret == $past(rd_data[15], 2))
    ##15 (ls_reg.ret == $past(rd_data[0], 17)))
    else $error("reply data bits wrong");

  a_revision_read: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && rd_ok && f_sel == `SEL_REVISION
    |=> ls_reg.shreg[15:0] == `LOGIC_REVISION)
    else $error("revision readback wrong");

  a_strap_read: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && rd_ok && f_sel == `SEL_STRAP_ID
    |=> ls_reg.shreg[15:0] == {11'h000, $past(strap_reg)})
    else $error("strap readback wrong");

  a_write_no_reject: assert property (@(posedge serial_cmd_clock) disable iff (lrst_reg)
    frame_done && wr_ok
    |=> $stable(ls_reg.rej_cnt))
    else $error("accepted write counted as reject");

  // ****************************************
  // Hold domain: channel select
  // ****************************************
  logic chan_sel_reg;

  // Value depends only on inputs at the hold edge, so no reset is needed
  always_ff @(posedge hold_in)
  begin
    if (config_out.cfg[`CFG_MANUAL])
      chan_sel_reg <= config_out.cfg[`CFG_RANGE];
    else
      chan_sel_reg <= range_overflow_comparator;
  end

  // ****************************************
  // System domain: config capture, hold, strobe
  // ****************************************
  serial_cmd_pkg::sys_state_type ss_reg;
  serial_cmd_pkg::sys_state_type ss_next;

  always_comb
  begin
    ss_next           = ss_reg;
    ss_next.tgl_meta  = ls_reg.wr_tgl;
    ss_next.tgl_sync  = ss_reg.tgl_meta;
    ss_next.tgl_seen  = ss_reg.tgl_sync;
    ss_next.hold_meta = hold_in;
    ss_next.hold_sync = ss_reg.hold_meta;
    ss_next.strb_meta = strobe_in;
    ss_next.strb_sync = ss_reg.strb_meta;
    ss_next.strb_prev = ss_reg.strb_sync;
    ss_next.chan_meta = chan_sel_reg;
    ss_next.chan_sync = ss_reg.chan_meta;
    // Link words are stable for many cycles after the toggle
    if (ss_reg.tgl_sync != ss_reg.tgl_seen)
    begin
      ss_next.cfg_out.cfg = ls_reg.cfg;
      ss_next.cfg_out.thr = ls_reg.thr;
    end
    ss_next.test_pulse = ss_reg.strb_sync && !ss_reg.strb_prev
                         && ss_reg.cfg_out.cfg[`CFG_TCI_EN];
    if (rst)
    begin
      ss_next             = '0;
      ss_next.cfg_out.cfg = `CONFIG_RESET;
      ss_next.cfg_out.thr = {5{`THR_RESET}};
    end
  end

  always_ff @(posedge mclk)
  begin
    ss_reg <= ss_next;
  end

  assign config_out        = ss_reg.cfg_out;
  assign sample_hold       = ss_reg.hold_sync;
  assign test_pulse        = ss_reg.test_pulse;
  assign channel_indicator = ss_reg.chan_sync;

  a_test_pulse: assert property (@(posedge mclk) disable iff (rst)
    ss_reg.strb_sync && !ss_reg.strb_prev && ss_reg.cfg_out.cfg[`CFG_TCI_EN]
    |=> test_pulse ##1 !test_pulse)
    else $error("test pulse not single");

  // ****************************************
  // System domain checks
  // ****************************************
  a_reset_outputs: assert property (@(posedge mclk)
    rst
    |=> !test_pulse && !sample_hold && !channel_indicator
        && config_out.cfg == `CONFIG_RESET)
    else $error("outputs not reset");

  a_hold_follow: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && !$past(rst, 2)
    |-> sample_hold == $past(hold_in, 2))
    else $error("sample hold does not follow hold input");

  a_config_quiet: assert property (@(posedge mclk) disable iff (rst)
    ss_reg.tgl_sync == ss_reg.tgl_seen
    |=> $stable(config_out))
    else $error("config output changed without a write");

  a_config_take: assert property (@(posedge mclk) disable iff (rst)
    ss_reg.tgl_sync != ss_reg.tgl_seen
    |=> config_out == $past({ls_reg.cfg, ls_reg.thr}))
    else $error("config output not taken after a write");

  a_pulse_gated: assert property (@(posedge mclk) disable iff (rst)
    !ss_reg.cfg_out.cfg[`CFG_TCI_EN]
    |=> !test_pulse)
    else $error("test pulse while disabled");

endmodule
`default_nettype wire

// ---- serial_cmd_core_defines.svh ----
// Constants of the serial configuration command core.
// Assumes inclusion by bare name; definitions only.
`ifndef SERIAL_CMD_CORE_DEFINES_SVH
`define SERIAL_CMD_CORE_DEFINES_SVH

// ****************************************
// Frame layout
// ****************************************
`define FRAME_LAST      5'd27
`define START_POS       27
`define RW_POS          26
`define ADDR_MSB        25
`define ADDR_LSB        21
`define SEL_MSB         20
`define SEL_LSB         17
`define DATA_MSB        16
`define DATA_LSB        1
`define REPLY_DATA_LAST 5'd15
`define BROADCAST_ADDR  5'h1f

// ****************************************
// Register select codes
// ****************************************
`define SEL_CONFIG     4'h0
`define SEL_THR5       4'h5
`define SEL_REVISION   4'h6
`define SEL_WRITE_CNT  4'h7
`define SEL_REJECT_CNT 4'h8
`define SEL_LOOP_CNT   4'h9
`define SEL_STRAP_ID   4'ha

// ****************************************
// Reset values and fields
// ****************************************
`define CONFIG_RESET   16'h0032
`define THR_RESET      6'h00
`define COUNT_RESET    6'h00
// Arbitrary revision value
`define LOGIC_REVISION 16'h00a5
`define CFG_TCI_EN     1
`define CFG_MANUAL     2
`define CFG_RANGE      3

`endif

// ---- serial_cmd_pkg.sv ----
// Types shared by the serial configuration command core.
// Assumes the constants header is compiled alongside.
package serial_cmd_pkg;

  typedef enum logic [2:0]
  {
    LINK_IDLE  = 3'b001,
    LINK_SHIFT = 3'b010,
    LINK_REPLY = 3'b100
  } link_phase_type;

  typedef struct packed
  {
    logic [15:0]      cfg;
    logic [4:0][5:0]  thr;
  } config_out_type;

  typedef struct packed
  {
    link_phase_type   phase;
    logic [26:0]      shreg;
    logic [4:0]       cnt;
    logic [15:0]      cfg;
    logic [4:0][5:0]  thr;
    logic [5:0]       wr_cnt;
    logic [5:0]       rej_cnt;
    logic [5:0]       loop_cnt;
    logic             ret;
    logic             wr_tgl;
  } link_state_type;

  typedef struct packed
  {
    logic             tgl_meta;
    logic             tgl_sync;
    logic             tgl_seen;
    logic             hold_meta;
    logic             hold_sync;
    logic             strb_meta;
    logic             strb_sync;
    logic             strb_prev;
    logic             chan_meta;
    logic             chan_sync;
    config_out_type   cfg_out;
    logic             test_pulse;
  } sys_state_type;

endpackage

// ---- serial_cmd_ctrl_model.sv ----
// Readout controller model that drives the serial command link.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Link controller
// ****************************************
module serial_cmd_ctrl_model
(
  output logic      serial_cmd_clock,
  output logic      serial_cmd_in,
  input  wire logic return_data
);
  initial
  begin
    serial_cmd_clock = 1'b0;
    serial_cmd_in    = 1'b0;
  end

  // One link bit, set while the clock is low
  task automatic tick(input logic b);
    serial_cmd_in = b;
    #24 serial_cmd_clock = 1'b1;
    #24 serial_cmd_clock = 1'b0;
  endtask

  // Frame, then 28 zeros; reply bits taken after each edge
  task automatic send(input logic [27:0] f, output logic [16:0] rep, output logic tail);
    tail = 1'b0;
    for (int i = 27; i >= 0; i--)
      tick(f[i]);
    rep[16] = return_data;
    for (int i = 15; i >= 0; i--)
    begin
      tick(1'b0);
      rep[i] = return_data;
    end
    for (int i = 0; i < 12; i++)
    begin
      tick(1'b0);
      tail = tail | return_data;
    end
  endtask
endmodule
`default_nettype wire

// ---- serial_config_command_core_tb.sv ----
// Self-checking bench for the serial configuration command core.
// Assumes the controller model and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "serial_cmd_core_defines.svh"
module serial_config_command_core_tb;
  localparam logic [4:0] own_addr = 5'h0b;
  logic                           mclk;
  logic                           rst;
  logic                           serial_cmd_clock;
  logic                           serial_cmd_in;
  logic                           hold_in;
  logic                           strobe_in;
  logic                           range_overflow_comparator;
  logic                           return_data;
  serial_cmd_pkg::config_out_type config_out;
  logic                           sample_hold;
  logic                           test_pulse;
  logic                           channel_indicator;
  int                             mismatches;
  int                             total_checks;
  int                             pulses;
  logic [5:0]                     exp_wr;
  logic [5:0]                     exp_rej;
  logic [5:0]                     nf;
  logic [15:0]                    exp_cfg;
  logic [4:0][5:0]                exp_thr;
  logic [2:0]                     b;

  serial_config_command_core dut_u
  (
    .mclk                      (mclk),
    .rst                       (rst),
    .serial_cmd_clock          (serial_cmd_clock),
    .serial_cmd_in             (serial_cmd_in),
    .id_strap_pins             (own_addr),
    .hold_in                   (hold_in),
    .strobe_in                 (strobe_in),
    .range_overflow_comparator (range_overflow_comparator),
    .return_data               (return_data),
    .config_out                (config_out),
    .sample_hold               (sample_hold),
    .test_pulse                (test_pulse),
    .channel_indicator         (channel_indicator)
  );

  serial_cmd_ctrl_model ctrl_u
  (
    .serial_cmd_clock (serial_cmd_clock),
    .serial_cmd_in    (serial_cmd_in),
    .return_data      (return_data)
  );

  always #5 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic summarize;
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [46:0] got, input logic [46:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  // One command frame with its expected reply
  task automatic cmd(input logic rw, input logic [4:0] adr, input logic [3:0] sel,
                     input logic [15:0] dat, input logic bad, input logic ok, input logic [15:0] exp);
    logic [27:0] f;
    logic [16:0] rep;
    logic        tail;
    f    = {1'b1, rw, adr, sel, dat, 1'b0};
    f[0] = ~^f[26:1] ^ bad;
    ctrl_u.send(f, rep, tail);
    check(47'(rep), (rw && ok) ? {30'h0, 1'b1, exp} : 47'h0, "reply");
    check(47'(tail), 47'h0, "reply tail");
    if (!rw && ok)
      exp_wr++;
    if (!ok)
      exp_rej++;
    nf++;
  endtask

  initial
  begin
    #500us;
    mismatches++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    hold_in = 1'b0;
    strobe_in = 1'b0;
    range_overflow_comparator = 1'b0;
    mismatches = 0;
    total_checks = 0;
    exp_wr = 6'h00;
    exp_rej = 6'h00;
    nf = 6'h00;
    exp_cfg = 16'h0032;
    exp_thr = '0;
    repeat (5) ctrl_u.tick(1'b0);
    @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) ctrl_u.tick(1'b0);
    check(47'(config_out), {1'b0, exp_cfg, exp_thr}, "reset config");
    cmd(1'b1, own_addr, 4'h7, 16'h0, 1'b0, 1'b1, 16'h0);
    cmd(1'b1, own_addr, 4'h6, 16'h0, 1'b0, 1'b1, `LOGIC_REVISION);
    cmd(1'b1, own_addr, 4'ha, 16'h0, 1'b0, 1'b1, {11'h0, own_addr});
    exp_cfg = 16'ha5c3;
    cmd(1'b0, own_addr, 4'h0, exp_cfg, 1'b0, 1'b1, 16'h0);
    for (int k = 1; k <= 5; k++)
    begin
      exp_thr[k - 1] = {2'b10, 4'(k)};
      cmd(1'b0, 5'h1f, 4'(k), {10'h0, exp_thr[k - 1]}, 1'b0, 1'b1, 16'h0);
    end
    cmd(1'b1, own_addr, 4'h0, 16'h0, 1'b0, 1'b1, exp_cfg);
    for (int k = 1; k <= 5; k++)
      cmd(1'b1, own_addr, 4'(k), 16'h0, 1'b0, 1'b1, {10'h0, exp_thr[k - 1]});
    check(47'(config_out), {1'b0, exp_cfg, exp_thr}, "config out");
    cmd(1'b0, own_addr, 4'h0, 16'h1234, 1'b1, 1'b0, 16'h0);
    cmd(1'b0, own_addr ^ 5'h01, 4'h0, 16'h1234, 1'b0, 1'b0, 16'h0);
    cmd(1'b1, 5'h1f, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    cmd(1'b1, own_addr ^ 5'h02, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    cmd(1'b0, own_addr, 4'h6, 16'h0001, 1'b0, 1'b0, 16'h0);
    cmd(1'b0, own_addr, 4'hb, 16'h0001, 1'b0, 1'b0, 16'h0);
    cmd(1'b1, own_addr, 4'hb, 16'h0, 1'b0, 1'b0, 16'h0);
    cmd(1'b1, own_addr, 4'h0, 16'h0, 1'b0, 1'b1, exp_cfg);
    cmd(1'b1, own_addr, 4'h8, 16'h0, 1'b0, 1'b1, {10'h0, exp_rej});
    cmd(1'b1, own_addr, 4'h9, 16'h0, 1'b0, 1'b1, {10'h0, nf});
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      exp_cfg = {12'h0, b[0], b[1], b[2], 1'b0};
      cmd(1'b0, own_addr, 4'h0, exp_cfg, 1'b0, 1'b1, 16'h0);
      @(posedge mclk);
      #1 range_overflow_comparator = b[2];
      @(posedge mclk);
      #1 hold_in = 1'b1;
      strobe_in = 1'b1;
      pulses = 0;
      repeat (10) @(negedge mclk) pulses += int'(test_pulse === 1'b1);
      check(47'(sample_hold), 47'h1, "hold");
      check(47'(channel_indicator), 47'(b[1] ? b[0] : b[2]), "channel");
      check(47'(pulses), 47'(b[2]), "test pulse");
      @(posedge mclk);
      #1 range_overflow_comparator = ~b[2];
      hold_in = 1'b0;
      strobe_in = 1'b0;
      repeat (10) @(negedge mclk);
      check(47'(channel_indicator), 47'(b[1] ? b[0] : b[2]), "channel held");
      check(47'(sample_hold), 47'h0, "track");
    end
    while (exp_wr != 6'h3f)
      cmd(1'b0, own_addr, 4'h1, {10'h0, exp_wr}, 1'b0, 1'b1, 16'h0);
    cmd(1'b1, own_addr, 4'h7, 16'h0, 1'b0, 1'b1, 16'h003f);
    exp_thr[0] = 6'h3f;
    cmd(1'b0, own_addr, 4'h1, 16'h003f, 1'b0, 1'b1, 16'h0);
    cmd(1'b1, own_addr, 4'h7, 16'h0, 1'b0, 1'b1, {10'h0, exp_wr});
    cmd(1'b1, own_addr, 4'h9, 16'h0, 1'b0, 1'b1, {10'h0, nf});
    check(47'(config_out), {1'b0, exp_cfg, exp_thr}, "final config");
    @(posedge mclk);
    #1 rst = 1'b1;
    repeat (5) ctrl_u.tick(1'b0);
    @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) ctrl_u.tick(1'b0);
    check(47'(config_out), {1'b0, `CONFIG_RESET, {5{`THR_RESET}}}, "config after reset");
    cmd(1'b1, own_addr, 4'h7, 16'h0, 1'b0, 1'b1, 16'h0);
    cmd(1'b1, own_addr, 4'h0, 16'h0, 1'b0, 1'b1, `CONFIG_RESET);
    summarize();
  end
endmodule
`default_nettype wire
